// >>> design/rcp_pkg.sv
package rcp_pkg;

  // register addresses on the four-bit register port
  localparam logic [3:0] ADDR_SEC   = 4'h0;
  localparam logic [3:0] ADDR_MIN   = 4'h1;
  localparam logic [3:0] ADDR_HOUR  = 4'h2;
  localparam logic [3:0] ADDR_ADJ   = 4'h7;
  localparam logic [3:0] ADDR_CTRL1 = 4'hE;
  localparam logic [3:0] ADDR_CTRL2 = 4'hF;

  // values after reset (power-up from zero volts)
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h10;
  localparam logic [6:0] ADJ_RESET   = 7'h00;
  localparam logic [7:0] TIME_RESET  = 8'h00;

  // control register 1 fields
  localparam int C1_WEEKLY_EN  = 7;
  localparam int C1_DAILY_EN   = 6;
  localparam int C1_HOUR24     = 5;
  localparam int C1_CLKDIS_A   = 4;
  localparam int C1_TEST       = 3;

  // control register 2 fields
  localparam int C2_VTH_SEL    = 7;
  localparam int C2_LOW_V      = 6;
  localparam int C2_SCRATCH    = 5;
  localparam int C2_HALT       = 4;
  localparam int C2_CLKDIS_B   = 3;
  localparam int C2_PIRQ       = 2;
  localparam int C2_WEEKLY_FLG = 1;
  localparam int C2_DAILY_FLG  = 0;

  // periodic interrupt select codes
  typedef enum logic [2:0] {
    PSEL_OFF   = 3'h0,
    PSEL_LOW   = 3'h1,
    PSEL_2HZ   = 3'h2,
    PSEL_1HZ   = 3'h3,
    PSEL_SEC   = 3'h4,
    PSEL_MIN   = 3'h5,
    PSEL_HOUR  = 3'h6,
    PSEL_MONTH = 3'h7
  } rcp_psel_t;

  // oscillator divider and adjustment timing
  localparam int OSC_HZ         = 32768;
  localparam int DIV_WIDTH      = 15;
  localparam int ADJ_PERIOD_S   = 20;
  localparam int ADJ_STEP_COUNT = 2;

endpackage

// >>> design/rcp_osc_if.sv
`timescale 1ns/1ns
// signals between the system-clock logic and the oscillator divider
interface rcp_osc_if;
  logic       sec_tgl;
  logic       half_low;
  logic       quarter_low;
  logic       clr_tgl;
  logic       adj_tgl;
  logic [6:0] adj_val;
  logic       clk_en;

  modport sys (input sec_tgl, half_low, quarter_low,
               output clr_tgl, adj_tgl, adj_val, clk_en);
  modport osc (output sec_tgl, half_low, quarter_low,
               input clr_tgl, adj_tgl, adj_val, clk_en);
endinterface

// >>> design/rcp_divider.sv
`timescale 1ns/1ns
module rcp_divider #(
  parameter int DIV_WIDTH = rcp_pkg::DIV_WIDTH
) (
  // oscillator clock and reset
  input  wire logic i_osc_clock,
  input  wire logic i_rst_n,
  // link to the system-clock side
  rcp_osc_if.osc    link,
  // open-drain enable of the sub-clock pin
  output logic      o_subclock_oe
);

  logic                 rst_q1;
  logic                 rst_n_osc;
  logic [2:0]           clr_s;
  logic [2:0]           adj_s;
  logic [1:0]           en_s;
  logic [6:0]           adj_q;
  logic [DIV_WIDTH-1:0] div;
  logic [4:0]           sec20;
  logic [7:0]           stall;
  logic                 clr_ev;
  logic                 adj_ev;

  ////////////////////////////////////////////////////////////////////////
  // reset release and crossings into the oscillator domain
  always_ff @(posedge i_osc_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_q1    <= 1'b0;
      rst_n_osc <= 1'b0;
    end
    else
    begin
      rst_q1    <= 1'b1;
      rst_n_osc <= rst_q1;
    end
  end

  // toggles pass three flops so the edge detect never reads stage one
  always_ff @(posedge i_osc_clock or negedge rst_n_osc)
  begin
    if (!rst_n_osc)
    begin
      clr_s <= 3'h0;
      adj_s <= 3'h0;
      en_s  <= 2'h0;
    end
    else
    begin
      clr_s <= {clr_s[1:0], link.clr_tgl};
      adj_s <= {adj_s[1:0], link.adj_tgl};
      en_s  <= {en_s[0], link.clk_en};
    end
  end

  assign clr_ev = clr_s[2] ^ clr_s[1];
  assign adj_ev = adj_s[2] ^ adj_s[1];

  // adjustment word is held steady by the sender, so sample it on the edge
  always_ff @(posedge i_osc_clock or negedge rst_n_osc)
  begin
    if (!rst_n_osc)
      adj_q <= 7'h00;
    else if (adj_ev)
      adj_q <= link.adj_val;
  end

  ////////////////////////////////////////////////////////////////////////
  // sub-second divider, seconds toggle and twenty-second adjustment
  always_ff @(posedge i_osc_clock or negedge rst_n_osc)
  begin
    if (!rst_n_osc)
    begin
      div          <= '0;
      sec20        <= 5'h00;
      stall        <= 8'h00;
      link.sec_tgl <= 1'b0;
    end
    else if (clr_ev)
    begin
      div   <= '0;
      sec20 <= 5'h00;
      stall <= 8'h00;
    end
    else if (stall != 8'h00)
      stall <= stall - 8'h01;
    else if (&div)
    begin
      link.sec_tgl <= ~link.sec_tgl;
      div          <= '0;
      if (sec20 == 5'(rcp_pkg::ADJ_PERIOD_S - 1))
      begin
        sec20 <= 5'h00;
        // sign bit clear stretches the second, set shortens it
        if (adj_q[6])
          div <= DIV_WIDTH'({adj_q[5:0], 1'b0});
        else
          stall <= {1'b0, adj_q[5:0], 1'b0};
      end
      else
        sec20 <= sec20 + 5'h01;
    end
    else
      div <= div + DIV_WIDTH'(1);
  end

  // low phases follow the divider so pulses lock to the seconds tick
  assign link.half_low    = ~div[DIV_WIDTH-1];
  assign link.quarter_low = ~div[DIV_WIDTH-2];

  // pin is pulled low during the low half of each oscillator cycle
  assign o_subclock_oe = en_s[1] & ~i_osc_clock;

endmodule

// >>> design/rcp_top.sv
`timescale 1ns/1ns
// How it works
// - 12-hour mode: noon 32, PM hours 21..31
// - clock out runs unless both disables set
// - codes 000 off, 001 low, 010/011 pulse
// - codes 100..111 level per second/minute/hour/month
// - pulse waveform locked to seconds increment
// - level output falls with seconds increment
// - adjustment shifts timing once per twenty seconds
// - seconds increment trails pulse falling edge slightly
// - seconds write clears divider, drives output low
// - halt gives control two reading 10h
// - threshold bit picks the high or low trip
// - low-voltage flag sticks, write zero rearms
// - scratch bit stores, cleared by halt flag
// - halt flag set on stop, stays set
// - halt detection only while chip enable low
// - halt clears control, adjustment, interrupts, enables clock
// - writing zero clears halt flag, one ignored
// - periodic flag mirrors low output, level clear
// - control one holds enables, format, select
module rcp_top (
  // clocks and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_osc_clock,
  // register port from the serial engine
  input  wire logic [3:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_write,
  output logic      [7:0] o_reg_rdata,
  // analog monitors and pins
  input  wire logic       i_chip_enable,
  input  wire logic       i_osc_halted,
  input  wire logic       i_below_high_th,
  input  wire logic       i_below_low_th,
  // calendar and alarm logic on the system clock
  input  wire logic       i_last_day_of_month,
  input  wire logic       i_weekly_match,
  input  wire logic       i_daily_match,
  // interrupt and clock pins
  output logic            o_periodic_irq_out_n,
  output logic            o_alarm_irq_out_one_n,
  output logic            o_alarm_irq_out_two_n,
  output logic            o_subclock_out,
  output logic            o_subclock_oe,
  output logic            o_test_mode
);

  rcp_osc_if link ();

  logic                rst_q1;
  logic                rst_n_sync;
  logic [1:0]          ce_s;
  logic [1:0]          halt_s;
  logic [1:0]          hi_s;
  logic [1:0]          lo_s;
  logic [2:0]          tick_s;
  logic [1:0]          half_s;
  logic [1:0]          quarter_s;
  logic [7:0]          ctrl1;
  logic [6:0]          adj;
  logic                vth_sel;
  logic                low_v;
  logic                scratch;
  logic                halt_flag;
  logic                clkdis_b;
  logic                level_flag;
  logic                weekly_flg;
  logic                daily_flg;
  logic [7:0]          sec;
  logic [7:0]          min;
  logic [7:0]          hour;
  logic                tick;
  logic                halt_set;
  logic                below;
  logic                wr_sec;
  logic                wr_c2;
  logic                level_mode;
  logic                level_ev;
  logic                periodic_low;
  logic [7:0]          next_rdata;
  rcp_pkg::rcp_psel_t  psel;

  ////////////////////////////////////////////////////////////////////////
  // helpers for bcd counting and hour formats

  function automatic logic [4:0] bcd2bin(input logic [7:0] v);
    // widen before the product so a tens digit of two is not cut
    bcd2bin = 5'(v[7:4]) * 5'hA + 5'(v[3:0]);
  endfunction

  function automatic logic [7:0] bin2bcd(input logic [4:0] b);
    bin2bcd = (b >= 5'h14) ? {4'h2, 4'(b - 5'h14)} :
              (b >= 5'h0A) ? {4'h1, 4'(b - 5'h0A)} : {4'h0, b[3:0]};
  endfunction

  function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                          input logic [7:0] last);
    if (v == last)
      bcd_next = 8'h00;
    else if (v[3:0] == 4'h9)
      bcd_next = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_next = v + 8'h01;
  endfunction

  // internal hours are 24-hour bcd; this builds the 12-hour reading
  function automatic logic [7:0] hour_to_12(input logic [7:0] h);
    logic [4:0] b;
    b = bcd2bin(h);
    if (b == 5'h00)
      hour_to_12 = 8'h12;
    else if (b < 5'h0C)
      hour_to_12 = h;
    else if (b == 5'h0C)
      hour_to_12 = 8'h32;
    else
      hour_to_12 = bin2bcd(b - 5'h0C) | 8'h20;
  endfunction

  function automatic logic [7:0] hour_from_12(input logic [7:0] w);
    logic [4:0] b;
    b = bcd2bin({2'b00, w[4:0]});
    if (b == 5'h0C)
      b = 5'h00;
    hour_from_12 = bin2bcd(w[5] ? b + 5'h0C : b);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_q1     <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_q1     <= 1'b1;
      rst_n_sync <= rst_q1;
    end
  end

  // the tick toggle has a third stage so the edge detect skips stage one
  always_ff @(posedge i_clock or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      ce_s      <= 2'h0;
      halt_s    <= 2'h0;
      hi_s      <= 2'h0;
      lo_s      <= 2'h0;
      tick_s    <= 3'h0;
      half_s    <= 2'h0;
      quarter_s <= 2'h0;
    end
    else
    begin
      ce_s      <= {ce_s[0], i_chip_enable};
      halt_s    <= {halt_s[0], i_osc_halted};
      hi_s      <= {hi_s[0], i_below_high_th};
      lo_s      <= {lo_s[0], i_below_low_th};
      tick_s    <= {tick_s[1:0], link.sec_tgl};
      half_s    <= {half_s[0], link.half_low};
      quarter_s <= {quarter_s[0], link.quarter_low};
    end
  end

  assign tick     = tick_s[2] ^ tick_s[1];
  assign halt_set = halt_s[1] & ~ce_s[1];
  assign below    = vth_sel ? lo_s[1] : hi_s[1];
  assign wr_sec   = i_reg_write && (i_reg_addr == rcp_pkg::ADDR_SEC);
  assign wr_c2    = i_reg_write && (i_reg_addr == rcp_pkg::ADDR_CTRL2);
  assign psel     = rcp_pkg::rcp_psel_t'(ctrl1[2:0]);
  assign level_mode = ctrl1[2];

  ////////////////////////////////////////////////////////////////////////
  // time counters
  always_ff @(posedge i_clock or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      sec  <= rcp_pkg::TIME_RESET;
      min  <= rcp_pkg::TIME_RESET;
      hour <= rcp_pkg::TIME_RESET;
    end
    else if (i_reg_write && i_reg_addr == rcp_pkg::ADDR_SEC)
      sec <= {1'b0, i_reg_wdata[6:0]};
    else if (i_reg_write && i_reg_addr == rcp_pkg::ADDR_MIN)
      min <= {1'b0, i_reg_wdata[6:0]};
    else if (i_reg_write && i_reg_addr == rcp_pkg::ADDR_HOUR)
      hour <= ctrl1[rcp_pkg::C1_HOUR24] ? {2'b00, i_reg_wdata[5:0]}
                                        : hour_from_12(i_reg_wdata);
    else if (tick)
    begin
      // seconds step a few microseconds after the pulse edge via sync
      sec <= bcd_next(sec, 8'h59);
      if (sec == 8'h59)
      begin
        min <= bcd_next(min, 8'h59);
        if (min == 8'h59)
          hour <= bcd_next(hour, 8'h23);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register 1 and adjustment register
  always_ff @(posedge i_clock or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      ctrl1 <= rcp_pkg::CTRL1_RESET;
      adj   <= rcp_pkg::ADJ_RESET;
    end
    else if (halt_set || halt_flag && !(wr_c2 && !i_reg_wdata[4]))
    begin
      // held cleared while the halt flag stands
      ctrl1 <= rcp_pkg::CTRL1_RESET;
      adj   <= rcp_pkg::ADJ_RESET;
    end
    else if (i_reg_write && i_reg_addr == rcp_pkg::ADDR_CTRL1)
      ctrl1 <= i_reg_wdata;
    else if (i_reg_write && i_reg_addr == rcp_pkg::ADDR_ADJ)
      adj <= i_reg_wdata[6:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // control register 2: sticky flags, halt set beats a clearing write
  always_ff @(posedge i_clock or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      vth_sel   <= rcp_pkg::CTRL2_RESET[rcp_pkg::C2_VTH_SEL];
      low_v     <= rcp_pkg::CTRL2_RESET[rcp_pkg::C2_LOW_V];
      scratch   <= rcp_pkg::CTRL2_RESET[rcp_pkg::C2_SCRATCH];
      halt_flag <= rcp_pkg::CTRL2_RESET[rcp_pkg::C2_HALT];
      clkdis_b  <= rcp_pkg::CTRL2_RESET[rcp_pkg::C2_CLKDIS_B];
    end
    else
    begin
      if (halt_set)
        halt_flag <= 1'b1;
      else if (wr_c2 && !i_reg_wdata[rcp_pkg::C2_HALT])
        halt_flag <= 1'b0;
      if (halt_set || halt_flag)
      begin
        vth_sel  <= 1'b0;
        low_v    <= 1'b0;
        scratch  <= 1'b0;
        clkdis_b <= 1'b0;
      end
      else
      begin
        // once set, monitoring stops until zero is written
        if (!low_v && below)
          low_v <= 1'b1;
        else if (wr_c2 && !i_reg_wdata[rcp_pkg::C2_LOW_V])
          low_v <= 1'b0;
        if (wr_c2)
        begin
          vth_sel  <= i_reg_wdata[rcp_pkg::C2_VTH_SEL];
          scratch  <= i_reg_wdata[rcp_pkg::C2_SCRATCH];
          clkdis_b <= i_reg_wdata[rcp_pkg::C2_CLKDIS_B];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // periodic interrupt: level events and flag
  always_comb
  begin
    level_ev = 1'b0;
    case (psel)
      rcp_pkg::PSEL_SEC:   level_ev = tick;
      rcp_pkg::PSEL_MIN:   level_ev = tick && sec == 8'h59;
      rcp_pkg::PSEL_HOUR:  level_ev = tick && sec == 8'h59
                                      && min == 8'h59;
      rcp_pkg::PSEL_MONTH: level_ev = tick && sec == 8'h59
                                      && min == 8'h59 && hour == 8'h23
                                      && i_last_day_of_month;
      default:             level_ev = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      level_flag <= 1'b0;
    else if (halt_set || halt_flag || !level_mode)
      level_flag <= 1'b0;
    else if (level_ev || wr_sec)
      level_flag <= 1'b1;
    else if (wr_c2 && !i_reg_wdata[rcp_pkg::C2_PIRQ])
      level_flag <= 1'b0;
  end

  // the output is low whenever the flag reads one
  always_comb
  begin
    case (psel)
      rcp_pkg::PSEL_OFF: periodic_low = 1'b0;
      rcp_pkg::PSEL_LOW: periodic_low = 1'b1;
      rcp_pkg::PSEL_2HZ: periodic_low = quarter_s[1];
      rcp_pkg::PSEL_1HZ: periodic_low = half_s[1];
      default:           periodic_low = level_flag;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm flags, only kept while their enable is set
  always_ff @(posedge i_clock or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      weekly_flg <= 1'b0;
      daily_flg  <= 1'b0;
    end
    else
    begin
      if (!ctrl1[rcp_pkg::C1_WEEKLY_EN] || halt_flag)
        weekly_flg <= 1'b0;
      else if (i_weekly_match)
        weekly_flg <= 1'b1;
      else if (wr_c2 && !i_reg_wdata[rcp_pkg::C2_WEEKLY_FLG])
        weekly_flg <= 1'b0;
      if (!ctrl1[rcp_pkg::C1_DAILY_EN] || halt_flag)
        daily_flg <= 1'b0;
      else if (i_daily_match)
        daily_flg <= 1'b1;
      else if (wr_c2 && !i_reg_wdata[rcp_pkg::C2_DAILY_FLG])
        daily_flg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, registered one cycle after the address
  always_comb
  begin
    next_rdata = 8'h00;
    if (i_reg_addr == rcp_pkg::ADDR_SEC)
      next_rdata = sec;
    else if (i_reg_addr == rcp_pkg::ADDR_MIN)
      next_rdata = min;
    else if (i_reg_addr == rcp_pkg::ADDR_HOUR)
      next_rdata = ctrl1[rcp_pkg::C1_HOUR24] ? hour : hour_to_12(hour);
    else if (i_reg_addr == rcp_pkg::ADDR_ADJ)
      next_rdata = {1'b0, adj};
    else if (i_reg_addr == rcp_pkg::ADDR_CTRL1)
      next_rdata = ctrl1;
    else if (i_reg_addr == rcp_pkg::ADDR_CTRL2)
      next_rdata = {vth_sel, low_v, scratch, halt_flag, clkdis_b,
                    periodic_low, weekly_flg, daily_flg};
  end

  // interrupt pins and read data come from flops
  always_ff @(posedge i_clock or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      o_reg_rdata           <= 8'h00;
      o_periodic_irq_out_n  <= 1'b1;
      o_alarm_irq_out_one_n <= 1'b1;
      o_alarm_irq_out_two_n <= 1'b1;
    end
    else
    begin
      o_reg_rdata           <= next_rdata;
      o_periodic_irq_out_n  <= ~periodic_low;
      o_alarm_irq_out_one_n <= ~weekly_flg;
      o_alarm_irq_out_two_n <= ~daily_flg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // signals toward the divider
  always_ff @(posedge i_clock or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      link.clr_tgl <= 1'b0;
      link.adj_tgl <= 1'b0;
    end
    else
    begin
      if (wr_sec)
        link.clr_tgl <= ~link.clr_tgl;
      if (i_reg_write && i_reg_addr == rcp_pkg::ADDR_ADJ || halt_set)
        link.adj_tgl <= ~link.adj_tgl;
    end
  end

  assign link.adj_val = adj;
  // two bits at two addresses keep a runaway write from killing the clock
  assign link.clk_en  = ~(ctrl1[rcp_pkg::C1_CLKDIS_A] & clkdis_b);
  assign o_subclock_out = 1'b0;
  assign o_test_mode    = ctrl1[rcp_pkg::C1_TEST];

  rcp_divider #(
    .DIV_WIDTH (rcp_pkg::DIV_WIDTH)
  ) u_divider (
    .i_osc_clock   (i_osc_clock),
    .i_rst_n       (i_rst_n),
    .link          (link.osc),
    .o_subclock_oe (o_subclock_oe)
  );

endmodule

// >>> test/rcp_top_asserts.sv
`timescale 1ns/1ns
// port-level checks of control and periodic interrupt logic
module rcp_checker (
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_write,
  input wire logic [7:0] o_reg_rdata,
  // pins
  input wire logic       i_osc_clock,
  input wire logic       i_chip_enable,
  input wire logic       i_osc_halted,
  input wire logic       o_periodic_irq_out_n,
  input wire logic       o_subclock_oe,
  input wire logic       o_test_mode
);
  ////////////////////////////////////////////////////////////
  logic       wr_c1;
  logic       wr_c2;
  logic       wr_test;
  logic       armed;
  logic [2:0] psel;
  // decoded writes to the two control registers
  assign wr_c1   = i_reg_write && i_reg_addr == 4'hE;
  assign wr_c2   = i_reg_write && i_reg_addr == 4'hF;
  assign wr_test = wr_c1 && i_reg_wdata[3];
  // control one only takes writes once the halt flag is cleared
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      armed <= 1'b0;
    else if (!i_chip_enable && i_osc_halted)
      armed <= 1'b0;
    else if (wr_c2 && !i_reg_wdata[4])
      armed <= 1'b1;
  // shadow select code; leads the design by the sync delay on halt
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      psel <= 3'h0;
    else if (!armed)
      psel <= 3'h0;
    else if (wr_c1)
      psel <= i_reg_wdata[2:0];
  ////////////////////////////////////////////////////////////
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // clear the halt flag, then present its address
  sequence s_clear_halt;
    wr_c2 && !i_reg_wdata[4] && i_chip_enable ##1 i_reg_addr == 4'hF;
  endsequence
  // seconds write while a pulse code is selected
  sequence s_sec_write;
    psel[2:1] == 2'b01 && i_reg_write && i_reg_addr == 4'h0;
  endsequence
  a_pull_osc_low: assert property (
    o_subclock_oe |-> !i_osc_clock) else $error("pin pulled while high");
  a_unmapped_zero: assert property (
    i_reg_addr == 4'hD |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_halt_clear: assert property (
    s_clear_halt |=> !o_reg_rdata[4]) else $error("halt flag not cleared");
  a_test_cause: assert property (
    $rose(o_test_mode) |-> $past(wr_test))
    else $error("test pin rose without a write");
  a_fixed_low: assert property (
    (psel == 3'h1)[*4] |-> !o_periodic_irq_out_n)
    else $error("code one not low");
  a_off_high: assert property (
    (psel == 3'h0)[*4] |-> o_periodic_irq_out_n)
    else $error("code zero not high");
  a_sec_write_low: assert property (
    s_sec_write |-> ##[1:12] !o_periodic_irq_out_n)
    else $error("seconds write left pin high");
  a_level_release: assert property (
    psel[2] && wr_c2 && !i_reg_wdata[2] |-> ##[1:2] o_periodic_irq_out_n)
    else $error("level pin not released");
endmodule
bind rcp_top rcp_checker rcp_checker_inst (
  .i_clock, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_write,
  .o_reg_rdata, .i_osc_clock, .i_chip_enable, .i_osc_halted,
  .o_periodic_irq_out_n, .o_subclock_oe, .o_test_mode
);

// >>> test/rcp_host.sv
`timescale 1ns/1ns
// host side of the register port, as left by the serial engine
module rcp_host (
  // clock
  input  wire logic       i_clock,
  // register port
  output logic      [3:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_write,
  input  wire logic [7:0] i_rdata
);
  // idle values at time zero
  initial
  begin
    o_addr  = 4'hD;
    o_wdata = 8'h00;
    o_write = 1'b0;
  end
  // one-cycle strobe; data inverted after so nothing stale lingers
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_addr  = a;
    o_wdata = d;
    o_write = 1'b1;
    @(negedge i_clock);
    o_write = 1'b0;
    o_wdata = ~d;
  endtask
  // data follows the address one cycle later
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_clock);
    o_addr = a;
    @(negedge i_clock);
    d = i_rdata;
  endtask
endmodule

// >>> test/rcp_tb_top.sv
`timescale 1ns/1ns
// reset checks first, then the register table, then the hand tests
module rcp_tb_top;
  logic       i_clock = 1'b0, i_osc_clock = 1'b0, i_rst_n = 1'b0;
  logic       chip_en = 1'b1, halted = 1'b0;
  logic       below_hi = 1'b0, below_lo = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rd;
  logic       write, irq_n, oe, test;
  int         errors = 0, total_checks = 0, n;
  // rows {write, address, data}: writes apply data, reads expect it
  localparam logic [12:0] ROWS [19] = '{
    13'h1F00, 13'h0F00, 13'h1F20, 13'h0F20,
    13'h1F30, 13'h0F20,
    13'h1E20, 13'h1213, 13'h1E00, 13'h0221,
    13'h1E20, 13'h1212, 13'h1E00, 13'h0232,
    13'h1EE3, 13'h0EE3, 13'h0D00, 13'h1E00, 13'h0E00};
  // system clock, and an unrelated oscillator clock
  always #20 i_clock = ~i_clock;
  initial #7 forever #16 i_osc_clock = ~i_osc_clock;
  ////////////////////////////////////////////////////////////
  rcp_top rcp_top_inst (
    .i_clock, .i_rst_n, .i_osc_clock, .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_write(write), .o_reg_rdata(rdata),
    .i_chip_enable(chip_en), .i_osc_halted(halted),
    .i_below_high_th(below_hi), .i_below_low_th(below_lo),
    .i_last_day_of_month(1'b0), .i_weekly_match(1'b0),
    .i_daily_match(1'b0), .o_periodic_irq_out_n(irq_n),
    .o_alarm_irq_out_one_n(), .o_alarm_irq_out_two_n(),
    .o_subclock_out(), .o_subclock_oe(oe), .o_test_mode(test));
  rcp_host rcp_host_inst (
    .i_clock, .o_addr(addr), .o_wdata(wdata), .o_write(write),
    .i_rdata(rdata));
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    rcp_host_inst.write_reg(a, d);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    rcp_host_inst.read_reg(a, rd);
    check("register", rd, exp);
  endtask
  // pulls seen on the sub-clock pin over twenty cycles
  task automatic count_oe;
    // let the enable cross into the oscillator domain first
    repeat (2) @(negedge i_clock);
    n = 0;
    repeat (20) @(negedge i_clock) n += (oe === 1'b1);
  endtask
  // bounded wait on the interrupt pin; running out ends the run
  task automatic wait_irq(input logic lvl, input int lim);
    while (irq_n !== lvl && lim-- > 0) @(negedge i_clock);
    if (irq_n !== lvl)
    begin
      errors++;
      close_out;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    rdc(4'hF, 8'h10);
    count_oe;
    check("clock after reset", 8'(n > 0), 8'h01);
    foreach (ROWS[i])
      if (ROWS[i][12])
        wr(ROWS[i][11:8], ROWS[i][7:0]);
      else
        rdc(ROWS[i][11:8], ROWS[i][7:0]);
    // both disables stop the clock pin, the control one disable alone does not
    wr(4'hE, 8'h10);
    wr(4'hF, 8'h08);
    count_oe;
    check("clock off", 8'(n), 8'h00);
    wr(4'hF, 8'h00);
    count_oe;
    check("clock on", 8'(n > 0), 8'h01);
    wr(4'hE, 8'h08);
    check("test pin", {7'h00, test}, 8'h01);
    wr(4'hE, 8'h01);
    repeat (4) @(negedge i_clock);
    check("fixed low", {7'h00, irq_n}, 8'h00);
    wr(4'hE, 8'h00);
    repeat (4) @(negedge i_clock);
    check("off", {7'h00, irq_n}, 8'h01);
    // low trip selected: high comparator alone is ignored
    wr(4'hF, 8'h80);
    below_hi = 1'b1;
    repeat (6) @(negedge i_clock);
    rdc(4'hF, 8'h80);
    below_lo = 1'b1;
    repeat (6) @(negedge i_clock);
    {below_hi, below_lo} = 2'b00;
    repeat (6) @(negedge i_clock);
    rdc(4'hF, 8'hC0);
    wr(4'hF, 8'hC0);
    rdc(4'hF, 8'hC0);
    wr(4'hF, 8'h80);
    rdc(4'hF, 8'h80);
    // level mode on the seconds tick, released by writing zero
    wr(4'hF, 8'h00);
    wr(4'hE, 8'h04);
    wait_irq(1'b0, 30000);
    rdc(4'hF, 8'h04);
    wr(4'hF, 8'h00);
    @(negedge i_clock);
    check("released", {7'h00, irq_n}, 8'h01);
    wr(4'hE, 8'h03);
    wait_irq(1'b1, 30000);
    wr(4'h0, 8'h00);
    wait_irq(1'b0, 12);
    check("seconds write", {7'h00, irq_n}, 8'h00);
    // mid-run reset puts both control registers back
    i_rst_n = 1'b0;
    repeat (4) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    rdc(4'hE, 8'h00);
    rdc(4'hF, 8'h10);
    // per-minute level event lands on the roll to 00 seconds
    wr(4'hF, 8'h00);
    wr(4'hE, 8'h05);
    wr(4'h0, 8'h59);
    wr(4'hF, 8'h00);
    @(negedge i_clock);
    check("minute release", {7'h00, irq_n}, 8'h01);
    wait_irq(1'b0, 30000);
    rdc(4'h0, 8'h00);
    rdc(4'h1, 8'h01);
    // halt only sensed while deselected, then clears control state
    wr(4'hE, 8'h30);
    wr(4'hF, 8'h28);
    halted = 1'b1;
    repeat (8) @(negedge i_clock);
    rdc(4'hF, 8'h28);
    chip_en = 1'b0;
    repeat (8) @(negedge i_clock);
    {halted, chip_en} = 2'b01;
    repeat (8) @(negedge i_clock);
    rdc(4'hF, 8'h10);
    rdc(4'hE, 8'h00);
    count_oe;
    check("clock after halt", 8'(n > 0), 8'h01);
    close_out;
  end
endmodule
